// >>> hw/usb_dev_pin_cfg_int_enable.sv
// Purpose: Hardware configuration and interrupt enable registers with pin logic
// Assumes: Host strobes are synchronous to clk; pins pass two flip-flops
// Notes: usb_bus_reset is observed only; it never touches the registers

`timescale 1ns/10ps
`default_nettype none

module usb_dev_pin_cfg_int_enable (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic cmd_stb,
    input wire logic wr_stb,
    input wire logic rd_stb,
    input wire logic [7:0] bus_din,
    output logic [7:0] rd_data,
    input wire logic chip_select_n,
    input wire logic vbus_present,
    input wire logic dma_acknowledge_in,
    input wire logic end_of_transfer_signal,
    input wire logic dma_req_int,
    input wire logic int_level_in,
    input wire logic int_event,
    input wire logic suspended,
    input wire logic usb_bus_reset,
    output logic dma_request_out,
    output logic dma_ack_active,
    output logic eot_active,
    output logic wakeup_req,
    output logic suspend_out,
    output logic int_out,
    output logic [31:0] int_enable,
    output logic [7:0] clock_config
);

    logic [15:0] cfg_q;
    logic [31:0] ie_q;
    logic [7:0] rd_data_q;
    logic [1:0] idx_q;
    usb_cfg_pkg::cmd_state_e state_q;
    logic [1:0] cs_sync_q;
    logic [1:0] vbus_sync_q;
    logic [1:0] ack_sync_q;
    logic [1:0] eot_sync_q;
    logic dma_request_q;
    logic dma_ack_q;
    logic eot_q;
    logic wakeup_q;
    logic suspend_q;
    logic int_q;
    logic pulse_active;
    logic int_src;
    logic acc_cfg_wr;
    logic acc_ie_wr;
    logic acc_rd;
    logic last_byte;
    logic [1:0] next_idx;

    // Pick one byte of a word, least significant first
    function automatic logic [7:0] byte_of(input logic [31:0] word, input logic [1:0] idx);
        logic [7:0] b;
        b = 8'h00;
        unique case (idx)
            2'h0: b = word[7:0];
            2'h1: b = word[15:8];
            2'h2: b = word[23:16];
            2'h3: b = word[31:24];
        endcase
        return b;
    endfunction : byte_of

    // Data strobes count only inside a matching command
    assign acc_cfg_wr = wr_stb && (state_q == usb_cfg_pkg::ST_CFG_WR);
    assign acc_ie_wr = wr_stb && (state_q == usb_cfg_pkg::ST_IE_WR);
    assign acc_rd = rd_stb && (state_q == usb_cfg_pkg::ST_CFG_RD || state_q == usb_cfg_pkg::ST_IE_RD);
    assign next_idx = idx_q + 2'h1;

    // Last byte of the command in progress
    always_comb begin
        last_byte = 1'b0;
        unique case (state_q)
            usb_cfg_pkg::ST_CFG_WR, usb_cfg_pkg::ST_CFG_RD: last_byte = (idx_q == usb_cfg_pkg::CFG_LAST_BYTE);
            usb_cfg_pkg::ST_IE_WR, usb_cfg_pkg::ST_IE_RD: last_byte = (idx_q == usb_cfg_pkg::IE_LAST_BYTE);
            usb_cfg_pkg::ST_IDLE: last_byte = 1'b0;
        endcase
    end

    // Command decode; unknown codes leave the block idle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= usb_cfg_pkg::ST_IDLE;
        end else if (cmd_stb) begin
            unique case (bus_din)
                usb_cfg_pkg::CMD_CFG_WR: state_q <= usb_cfg_pkg::ST_CFG_WR;
                usb_cfg_pkg::CMD_CFG_RD: state_q <= usb_cfg_pkg::ST_CFG_RD;
                usb_cfg_pkg::CMD_IE_WR: state_q <= usb_cfg_pkg::ST_IE_WR;
                usb_cfg_pkg::CMD_IE_RD: state_q <= usb_cfg_pkg::ST_IE_RD;
                default: state_q <= usb_cfg_pkg::ST_IDLE;
            endcase
        end else if ((acc_cfg_wr || acc_ie_wr || acc_rd) && last_byte) begin
            state_q <= usb_cfg_pkg::ST_IDLE;
        end
    end

    // Byte index, restarting at the least significant byte
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            idx_q <= 2'h0;
        end else if (cmd_stb) begin
            idx_q <= 2'h0;
        end else if (acc_cfg_wr || acc_ie_wr || acc_rd) begin
            idx_q <= next_idx;
        end
    end

    // Configuration register; bus reset has no path here
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_q <= usb_cfg_pkg::CFG_RESET;
        end else if (acc_cfg_wr) begin
            if (idx_q[0]) begin
                cfg_q[15:8] <= bus_din;
            end else begin
                cfg_q[7:0] <= bus_din;
            end
        end
    end

    // Interrupt enable register, one bit per source; bus reset ignored
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ie_q <= usb_cfg_pkg::IE_RESET;
        end else if (acc_ie_wr) begin
            ie_q[8 * idx_q +: 8] <= bus_din;
        end
    end

    // Read data: first byte on the command, next byte on each read
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data_q <= 8'h00;
        end else if (cmd_stb && bus_din == usb_cfg_pkg::CMD_CFG_RD) begin
            rd_data_q <= cfg_q[7:0];
        end else if (cmd_stb && bus_din == usb_cfg_pkg::CMD_IE_RD) begin
            rd_data_q <= ie_q[7:0];
        end else if (acc_rd && !last_byte) begin
            rd_data_q <= byte_of(state_q == usb_cfg_pkg::ST_IE_RD ? ie_q : {16'h0000, cfg_q}, next_idx);
        end
    end

    // Two-stage synchronisers for the pins
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cs_sync_q <= 2'b11;
            vbus_sync_q <= 2'b00;
            // Start at the idle high level of the active-low reset polarity, so no false strobe follows reset
            ack_sync_q <= 2'b11;
            eot_sync_q <= 2'b11;
        end else begin
            cs_sync_q <= {cs_sync_q[0], chip_select_n};
            vbus_sync_q <= {vbus_sync_q[0], vbus_present};
            ack_sync_q <= {ack_sync_q[0], dma_acknowledge_in};
            eot_sync_q <= {eot_sync_q[0], end_of_transfer_signal};
        end
    end

    // DMA pin polarities
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dma_request_q <= 1'b0;
            dma_ack_q <= 1'b0;
            eot_q <= 1'b0;
        end else begin
            dma_request_q <= cfg_q[usb_cfg_pkg::DMA_REQUEST_POLARITY_BIT] ? dma_req_int : !dma_req_int;
            dma_ack_q <= cfg_q[usb_cfg_pkg::DMA_ACKNOWLEDGE_POLARITY_BIT] ? ack_sync_q[1] : !ack_sync_q[1];
            eot_q <= cfg_q[usb_cfg_pkg::END_OF_TRANSFER_POLARITY_BIT] ? eot_sync_q[1] : !eot_sync_q[1];
        end
    end

    // Wake-up on low chip select and power switch during suspend
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wakeup_q <= 1'b0;
            suspend_q <= 1'b0;
        end else begin
            wakeup_q <= cfg_q[usb_cfg_pkg::CHIP_SELECT_WAKEUP_ENABLE_BIT] && suspended
                        && vbus_sync_q[1] && !cs_sync_q[1];
            suspend_q <= cfg_q[usb_cfg_pkg::SUSPEND_POWER_OFF_ENABLE_BIT] && suspended;
        end
    end

    // Pulse source for pulsed interrupt mode
    int_pulse_gen #(
        .CYCLES(usb_cfg_pkg::INT_PULSE_CYCLES)
    ) u_int_pulse (
        .clk(clk),
        .rst_n(rst_n),
        .trig(int_event),
        .active(pulse_active)
    );

    // Interrupt source by mode, then polarity
    assign int_src = cfg_q[usb_cfg_pkg::INTERRUPT_SIGNALLING_MODE_BIT] ? pulse_active : int_level_in;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            int_q <= 1'b1;
        end else begin
            int_q <= cfg_q[usb_cfg_pkg::INTERRUPT_OUTPUT_POLARITY_BIT] ? int_src : !int_src;
        end
    end

    assign rd_data = rd_data_q;
    assign dma_request_out = dma_request_q;
    assign dma_ack_active = dma_ack_q;
    assign eot_active = eot_q;
    assign wakeup_req = wakeup_q;
    assign suspend_out = suspend_q;
    assign int_out = int_q;
    assign int_enable = ie_q;
    assign clock_config = cfg_q[15:8];

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    sequence s_pulse_start;
        !pulse_active ##1 pulse_active;
    endsequence

    sequence s_pulse_body;
        pulse_active ##1 !pulse_active;
    endsequence

    a_drq_polarity: assert property (
        1 |=> dma_request_out == ($past(cfg_q[usb_cfg_pkg::DMA_REQUEST_POLARITY_BIT])
            ? $past(dma_req_int) : !$past(dma_req_int)))
        else $error("DMA request polarity wrong");

    a_ack_polarity: assert property (
        1 |=> dma_ack_active == ($past(cfg_q[usb_cfg_pkg::DMA_ACKNOWLEDGE_POLARITY_BIT])
            ? $past(ack_sync_q[1]) : !$past(ack_sync_q[1])))
        else $error("DMA acknowledge polarity wrong");

    a_eot_polarity: assert property (
        1 |=> eot_active == ($past(cfg_q[usb_cfg_pkg::END_OF_TRANSFER_POLARITY_BIT])
            ? $past(eot_sync_q[1]) : !$past(eot_sync_q[1])))
        else $error("End of transfer polarity wrong");

    a_wakeup_cause: assert property (
        wakeup_req |-> $past(cfg_q[usb_cfg_pkg::CHIP_SELECT_WAKEUP_ENABLE_BIT]) && $past(suspended)
            && $past(vbus_sync_q[1]) && !$past(cs_sync_q[1]))
        else $error("Wake-up without its cause");

    a_suspend_power: assert property (
        (cfg_q[usb_cfg_pkg::SUSPEND_POWER_OFF_ENABLE_BIT] && suspended) |=> suspend_out)
        else $error("Suspend output not high in suspend");

    a_int_level: assert property (
        (!cfg_q[usb_cfg_pkg::INTERRUPT_SIGNALLING_MODE_BIT] && int_level_in)
            |=> int_out == $past(cfg_q[usb_cfg_pkg::INTERRUPT_OUTPUT_POLARITY_BIT]))
        else $error("Level interrupt not shown");

    a_pulse_length: assert property (
        s_pulse_start |=> s_pulse_body)
        else $error("Interrupt pulse not two cycles");

    a_int_idle_level: assert property (
        !int_src |=> int_out == !$past(cfg_q[usb_cfg_pkg::INTERRUPT_OUTPUT_POLARITY_BIT]))
        else $error("Idle interrupt polarity wrong");

    a_cfg_hold: assert property (
        (usb_bus_reset && !acc_cfg_wr) |=> $stable(cfg_q))
        else $error("Bus reset changed configuration");

    a_ie_write: assert property (
        (acc_ie_wr && idx_q == 2'h3) |=> ie_q[31:24] == $past(bus_din) && state_q == usb_cfg_pkg::ST_IDLE)
        else $error("Last enable byte not taken");

    a_ie_hold: assert property (
        (usb_bus_reset && !acc_ie_wr) |=> $stable(ie_q))
        else $error("Bus reset changed interrupt enables");

    a_cfg_read_lsb: assert property (
        (cmd_stb && bus_din == usb_cfg_pkg::CMD_CFG_RD) |=> rd_data == $past(cfg_q[7:0]))
        else $error("Configuration read not low byte first");

endmodule : usb_dev_pin_cfg_int_enable

`default_nettype wire

// >>> hw/usb_cfg_pkg.sv
// Purpose: Shared constants for the pin configuration and interrupt enable block
// Assumes: One 10 MHz clock; host commands arrive as byte strobes on that clock
// Notes: Interrupt enable reset value is a plain default, nothing fixes it

package usb_cfg_pkg;

    // Command codes on the host parallel interface
    localparam logic [7:0] CMD_CFG_WR = 8'hBA;
    localparam logic [7:0] CMD_CFG_RD = 8'hBB;
    localparam logic [7:0] CMD_IE_WR = 8'hC2;
    localparam logic [7:0] CMD_IE_RD = 8'hC3;

    // Index of the last byte of each register
    localparam logic [1:0] CFG_LAST_BYTE = 2'h1;
    localparam logic [1:0] IE_LAST_BYTE = 2'h3;

    // Hardware configuration lower byte field positions
    localparam int DMA_REQUEST_POLARITY_BIT = 6;
    localparam int DMA_ACKNOWLEDGE_POLARITY_BIT = 5;
    localparam int END_OF_TRANSFER_POLARITY_BIT = 4;
    localparam int CHIP_SELECT_WAKEUP_ENABLE_BIT = 3;
    localparam int SUSPEND_POWER_OFF_ENABLE_BIT = 2;
    localparam int INTERRUPT_SIGNALLING_MODE_BIT = 1;
    localparam int INTERRUPT_OUTPUT_POLARITY_BIT = 0;

    // Reset values
    localparam logic [15:0] CFG_RESET = 16'h2340;
    localparam logic [31:0] IE_RESET = 32'h00000000;

    // Interrupt pulse timing: least time, rounded up to whole cycles
    localparam int CLK_PERIOD_NS = 100;
    localparam int INT_PULSE_NS = 166;
    localparam int INT_PULSE_CYCLES = (INT_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Command decode states
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_CFG_WR,
        ST_CFG_RD,
        ST_IE_WR,
        ST_IE_RD
    } cmd_state_e;

endpackage : usb_cfg_pkg

// >>> hw/int_pulse_gen.sv
// Purpose: Fixed-length pulse generator for the pulsed interrupt mode
// Assumes: trig is a one-cycle event from logic on the same clock
// Notes: An event during a pulse is held and gives a second pulse after a gap

`timescale 1ns/10ps
`default_nettype none

module int_pulse_gen #(
    parameter int CYCLES = 2
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic trig,
    output logic active
);

    logic [7:0] cnt_q;
    logic pend_q;

    // Count down the pulse; a new one starts only from idle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= 8'h00;
        end else if (cnt_q != 8'h00) begin
            cnt_q <= cnt_q - 8'h01;
        end else if (trig || pend_q) begin
            cnt_q <= CYCLES[7:0];
        end
    end

    // Remember one event that arrived while busy
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pend_q <= 1'b0;
        end else if (cnt_q != 8'h00 && trig) begin
            pend_q <= 1'b1;
        end else if (cnt_q == 8'h00) begin
            pend_q <= 1'b0;
        end
    end

    assign active = (cnt_q != 8'h00);

endmodule : int_pulse_gen

`default_nettype wire

// >>> tb/host_cmd_model.sv
// Purpose: Host microcontroller model that issues register commands
// Assumes: Strobes change one step after a rising edge, one byte per cycle
// Notes: A released data bus shows the inverse of the last byte driven
`timescale 1ns/10ps
`default_nettype none
module host_cmd_model (
    input wire logic clk,
    output logic cmd_stb,
    output logic wr_stb,
    output logic rd_stb,
    output logic [7:0] bus_din,
    input wire logic [7:0] rd_data
);
    // Idle bus at time zero
    initial begin
        cmd_stb = 1'b0;
        wr_stb = 1'b0;
        rd_stb = 1'b0;
        bus_din = 8'h00;
    end

    // Byte count follows from the command code
    function automatic int nbytes(input logic [7:0] code);
        return (code == usb_cfg_pkg::CMD_IE_WR || code == usb_cfg_pkg::CMD_IE_RD) ? 4 : 2;
    endfunction : nbytes

    // Command byte, then data bytes least significant first
    task automatic write_reg(input logic [7:0] code, input logic [31:0] val);
        @(posedge clk);
        #1;
        cmd_stb = 1'b1;
        bus_din = code;
        for (int i = 0; i < nbytes(code); i++) begin
            @(posedge clk);
            #1;
            cmd_stb = 1'b0;
            wr_stb = 1'b1;
            bus_din = val[8*i +: 8];
        end
        @(posedge clk);
        #1;
        wr_stb = 1'b0;
        bus_din = ~bus_din;
    endtask : write_reg

    // Each read byte stands from one step after an edge; it is taken with its read strobe
    task automatic read_reg(input logic [7:0] code, output logic [31:0] val);
        val = 32'h00000000;
        @(posedge clk);
        #1;
        cmd_stb = 1'b1;
        bus_din = code;
        @(posedge clk);
        #1;
        cmd_stb = 1'b0;
        bus_din = ~code;
        for (int i = 0; i < nbytes(code); i++) begin
            rd_stb = 1'b1;
            val[8*i +: 8] = rd_data;
            @(posedge clk);
            #1;
        end
        rd_stb = 1'b0;
    endtask : read_reg

    // Firmware start-up always sets the power-off enable
    task automatic fw_init();
        write_reg(usb_cfg_pkg::CMD_CFG_WR, {16'h0000, usb_cfg_pkg::CFG_RESET | 16'h0004});
    endtask : fw_init
endmodule : host_cmd_model
`default_nettype wire

// >>> tb/usb_dev_pin_cfg_int_enable_tb_top.sv
// Purpose: Self-checking bench for the configuration and interrupt enable block
// Assumes: Pins are driven one step after the edge; pin latency is three cycles
// Notes: Pin results are sampled five cycles after each change
`timescale 1ns/10ps
`default_nettype none
`define check(name, exp, got) \
    begin \
        num_checks++; \
        if ((got) !== (exp)) begin \
            fail_count++; \
            $display("Error %s expected %h seen %h", name, exp, got); \
        end \
    end
module usb_dev_pin_cfg_int_enable_tb_top;
    logic clk, rst_n, cmd_stb, wr_stb, rd_stb, chip_select_n, vbus_present, dma_acknowledge_in;
    logic end_of_transfer_signal, dma_req_int, int_level_in, int_event, suspended, usb_bus_reset;
    logic dma_request_out, dma_ack_active, eot_active, wakeup_req, suspend_out, int_out;
    logic [7:0] bus_din, rd_data, clock_config;
    logic [31:0] int_enable, rv;
    int fail_count = 0;
    int num_checks = 0;
    int n;

    usb_dev_pin_cfg_int_enable dut_u (.clk, .rst_n, .cmd_stb, .wr_stb, .rd_stb, .bus_din, .rd_data,
        .chip_select_n, .vbus_present, .dma_acknowledge_in, .end_of_transfer_signal, .dma_req_int,
        .int_level_in, .int_event, .suspended, .usb_bus_reset, .dma_request_out, .dma_ack_active,
        .eot_active, .wakeup_req, .suspend_out, .int_out, .int_enable, .clock_config);
    host_cmd_model host_u (.clk, .cmd_stb, .wr_stb, .rd_stb, .bus_din, .rd_data);

    // Clock of 100 ns period
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // Watchdog far beyond the expected run length
    initial begin
        #2000000;
        fail_count++;
        $display("Error watchdog expired");
        end_sim();
    end

    task automatic settle();
        repeat (5) @(posedge clk);
        #1;
    endtask : settle

    task automatic set_cfg(input logic [15:0] v);
        host_u.write_reg(usb_cfg_pkg::CMD_CFG_WR, {16'h0000, v});
        settle();
    endtask : set_cfg

    task automatic test_reset_values();
        `check("clock_config", usb_cfg_pkg::CFG_RESET[15:8], clock_config)
        host_u.read_reg(usb_cfg_pkg::CMD_CFG_RD, rv);
        `check("cfg read", {16'h0000, usb_cfg_pkg::CFG_RESET}, rv)
        host_u.read_reg(usb_cfg_pkg::CMD_IE_RD, rv);
        `check("ie read", usb_cfg_pkg::IE_RESET, rv)
        $display("test_reset_values done");
    endtask : test_reset_values

    task automatic test_ie_access();
        host_u.fw_init();
        host_u.write_reg(usb_cfg_pkg::CMD_IE_WR, 32'hA5C31E96);
        `check("int_enable", 32'hA5C31E96, int_enable)
        host_u.read_reg(usb_cfg_pkg::CMD_IE_RD, rv);
        `check("ie read", 32'hA5C31E96, rv)
        $display("test_ie_access done");
    endtask : test_ie_access

    task automatic test_polarity();
        logic [7:0] lo;
        for (int i = 0; i < 4; i++) begin
            lo = {1'b0, i[0], i[1], i[0], 1'b0, 1'b1, 1'b0, i[1]};
            set_cfg({8'h23, lo});
            host_u.read_reg(usb_cfg_pkg::CMD_CFG_RD, rv);
            `check("cfg read", {24'h000023, lo}, rv)
            for (int a = 0; a < 2; a++) begin
                dma_req_int = a[0];
                int_level_in = a[0];
                dma_acknowledge_in = ~(a[0] ^ i[1]);
                end_of_transfer_signal = ~(a[0] ^ i[0]);
                settle();
                `check("dma_request_out", ~(a[0] ^ i[0]), dma_request_out)
                `check("dma_ack_active", a[0], dma_ack_active)
                `check("eot_active", a[0], eot_active)
                `check("int_out level", ~(a[0] ^ i[1]), int_out)
            end
        end
        int_level_in = 1'b0;
        dma_req_int = 1'b0;
        $display("test_polarity done");
    endtask : test_polarity

    task automatic test_pulse();
        set_cfg(16'h2347);
        `check("int_out idle", 1'b0, int_out)
        // One event, then an event held over two edges that must give a second pulse
        for (int k = 1; k < 3; k++) begin
            int_event = 1'b1;
            n = 0;
            for (int c = 0; c < 10; c++) begin
                @(posedge clk);
                #1;
                if (c == k - 1) begin
                    int_event = 1'b0;
                end
                n += (int_out === 1'b1);
            end
            `check("pulse cycles", k * usb_cfg_pkg::INT_PULSE_CYCLES, n)
        end
        $display("test_pulse done");
    endtask : test_pulse

    task automatic test_wakeup();
        set_cfg(16'h234C);
        suspended = 1'b1;
        chip_select_n = 1'b0;
        settle();
        `check("wakeup_req", 1'b1, wakeup_req)
        `check("suspend_out", 1'b1, suspend_out)
        vbus_present = 1'b0;
        settle();
        `check("wakeup no power", 1'b0, wakeup_req)
        vbus_present = 1'b1;
        set_cfg(16'h2340);
        `check("wakeup disabled", 1'b0, wakeup_req)
        `check("suspend_out off", 1'b0, suspend_out)
        suspended = 1'b0;
        chip_select_n = 1'b1;
        $display("test_wakeup done");
    endtask : test_wakeup

    task automatic test_bus_reset();
        set_cfg(16'h1575);
        usb_bus_reset = 1'b1;
        repeat (3) @(posedge clk);
        #1;
        usb_bus_reset = 1'b0;
        host_u.read_reg(usb_cfg_pkg::CMD_CFG_RD, rv);
        `check("cfg after bus reset", 32'h00001575, rv)
        host_u.read_reg(usb_cfg_pkg::CMD_IE_RD, rv);
        `check("ie after bus reset", 32'hA5C31E96, rv)
        $display("test_bus_reset done");
    endtask : test_bus_reset

    task automatic end_sim();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : end_sim

    // Main sequence
    initial begin
        rst_n = 1'b0;
        chip_select_n = 1'b1;
        vbus_present = 1'b1;
        dma_acknowledge_in = 1'b1;
        end_of_transfer_signal = 1'b1;
        dma_req_int = 1'b0;
        int_level_in = 1'b0;
        int_event = 1'b0;
        suspended = 1'b0;
        usb_bus_reset = 1'b0;
        repeat (6) @(posedge clk);
        #1;
        rst_n = 1'b1;
        test_reset_values();
        test_ie_access();
        test_polarity();
        test_pulse();
        test_wakeup();
        test_bus_reset();
        end_sim();
    end
endmodule : usb_dev_pin_cfg_int_enable_tb_top
`undef check
`default_nettype wire
